// ---- logic/rfi_regs.svh ----
// register map, field masks and reset values of the rf irq block
`ifndef RFI_REGS_SVH
`define RFI_REGS_SVH

// byte addresses on the apb register bus
`define RFI_OFF_PENDING_STATUS 16'h3fe0
`define RFI_OFF_SOURCE_ENABLE 16'h3fe4
`define RFI_OFF_STATUS_CLEAR 16'h3fe8
`define RFI_OFF_STATUS_FORCE 16'h3fec
`define RFI_OFF_BLK_EVENT 16'h3ff0
`define RFI_OFF_BLK_MASK 16'h3ff4

// bits 29:24, 22:8 and 5:0 carry sources
`define RFI_SRC_MASK 32'h3f7f_ff3f
// bits 14:13 are kept for internal use
`define RFI_INT_LSB 13
`define RFI_INT_MASK 32'h0000_6000
`define RFI_ENABLE_RST 32'h0000_0000
`define RFI_PENDING_RST 32'h0000_0000

// block event bits: unmapped access, event merged into a set flag
`define RFI_BLK_W 2
`define RFI_BLK_UNMAPPED 0
`define RFI_BLK_MERGED 1
`define RFI_BLK_RST 2'h0

`endif

// ---- logic/rfi_pkg.sv ----
// types shared by the rf irq block
`default_nettype none
package rfi_pkg;

  // one apb request as seen by the slave
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [15:0] addr;
    logic [31:0] wdata;
  } rfi_apb_req_s;

  // register selected by the address decoder
  typedef enum logic [2:0] {
    RFI_REG_NONE = 3'h0,
    RFI_REG_PENDING = 3'h1,
    RFI_REG_ENABLE = 3'h2,
    RFI_REG_CLEAR = 3'h3,
    RFI_REG_FORCE = 3'h4,
    RFI_REG_BLK_EVENT = 3'h5,
    RFI_REG_BLK_MASK = 3'h6
  } rfi_reg_e;

  // strobes of one accepted access
  typedef struct packed {
    logic wr;
    logic rd;
    rfi_reg_e sel;
    logic [31:0] wdata;
  } rfi_acc_s;

endpackage
`default_nettype wire

// ---- logic/rfi_apb_if.sv ----
// apb slave protocol: zero-wait answer, registered read data and error
`default_nettype none
module rfi_apb_if (
  input wire logic clk,
  input wire logic rst,
  input wire rfi_pkg::rfi_apb_req_s req,
  input wire rfi_pkg::rfi_reg_e sel,
  input wire logic [31:0] rdata_next,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output rfi_pkg::rfi_acc_s acc
);

  typedef struct packed {
    logic [31:0] prdata;
    logic slverr;
  } rfi_apb_st_s;

  rfi_apb_st_s st_q;
  rfi_apb_st_s st_d;
  logic setup;
  logic access;

  assign setup = req.sel & ~req.enable;
  assign access = req.sel & req.enable;

  // data and error are caught in the setup cycle so the access
  // phase can finish at once with both coming from flip-flops
  always_comb begin
    st_d = st_q;
    if (setup) begin
      st_d.prdata = req.write ? 32'h0000_0000 : rdata_next;
      st_d.slverr = (sel == rfi_pkg::RFI_REG_NONE);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // never stalls: every access completes in its first access cycle
  assign pready = 1'b1;
  assign prdata = st_q.prdata;
  assign pslverr = access & st_q.slverr;
  assign acc.wr = access & req.write;
  assign acc.rd = access & ~req.write;
  assign acc.sel = sel;
  assign acc.wdata = req.wdata;

endmodule
`default_nettype wire

// ---- logic/rfi_pending.sv ----
// sticky pending flags with hardware set, software force and clear
`default_nettype none
`include "rfi_regs.svh"
module rfi_pending #(
  parameter int W = 32,
  parameter logic [31:0] SRC_MASK = `RFI_SRC_MASK
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] evt,
  input wire logic [W-1:0] clr,
  input wire logic [W-1:0] force_set,
  output logic [W-1:0] flags,
  output logic merged
);

  typedef struct packed {
    logic [W-1:0] flags;
    logic merged;
  } rfi_pend_st_s;

  rfi_pend_st_s st_q;
  rfi_pend_st_s st_d;
  logic [W-1:0] setm;

  // elaboration stops on a width the source mask cannot serve
  if (W != 32) begin
    $error("rfi_pending: W must be 32");
  end

  // a set in the clearing cycle wins so no event is lost
  always_comb begin
    setm = (evt | force_set) & SRC_MASK[W-1:0];
    st_d.flags = ((st_q.flags & ~clr) | setm) & SRC_MASK[W-1:0];
    st_d.merged = |(evt & st_q.flags & ~clr);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q.flags <= `RFI_PENDING_RST;
      st_q.merged <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flags = st_q.flags;
  assign merged = st_q.merged;

endmodule
`default_nettype wire

// ---- logic/rfi_top.sv ----
// rf front-end interrupt enable and status-clear block
//
// Overview of operation
// - enabled pending flag reaches cpu interrupt
// - enable bits 29:24, 22:8, 5:0 match flags
// - writing 1 to clear drops that flag
// - bits 31:30, 23, 7:6 reserved, read 0
// - bits 14:13 from driver or nvm defaults
// - hardware event sets flag until cleared
// - writing 1 to force sets that flag
//
// The implementer's own choice: the APB register port.
`default_nettype none
`include "rfi_regs.svh"
module rfi_top #(
  parameter int ADDR_W = 16
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [31:0] EVENT_IN,
  input wire logic NVM_LOAD,
  input wire logic [1:0] NVM_INTERNAL,
  output logic [31:0] PENDING_OUT,
  output logic IRQ_OUT,
  output logic BLK_IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // checks and state

  // elaboration stops on an address width the decoder cannot serve
  if (ADDR_W < 14 || ADDR_W > 16) begin
    $error("rfi_top: ADDR_W must lie in 14..16");
  end

  typedef struct packed {
    logic [31:0] enable;
    logic [`RFI_BLK_W-1:0] blk_event;
    logic [`RFI_BLK_W-1:0] blk_mask;
    logic [`RFI_BLK_W-1:0] blk_snap;
  } rfi_top_st_s;

  rfi_top_st_s st_q;
  rfi_top_st_s st_d;

  rfi_pkg::rfi_apb_req_s req;
  rfi_pkg::rfi_reg_e sel;
  rfi_pkg::rfi_acc_s acc;
  logic [31:0] rdata_next;
  logic [31:0] pend;
  logic [31:0] clr_bits;
  logic [31:0] force_bits;
  logic merged;
  logic [`RFI_BLK_W-1:0] blk_new;
  logic setup_rd_blk;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // only the six mapped word addresses hit; anything else is answered with an error
  function automatic rfi_pkg::rfi_reg_e decode(
    input logic [15:0] addr
  );
    rfi_pkg::rfi_reg_e r;
    r = rfi_pkg::RFI_REG_NONE;
    case (addr)
      `RFI_OFF_PENDING_STATUS: begin
        r = rfi_pkg::RFI_REG_PENDING;
      end
      `RFI_OFF_SOURCE_ENABLE: begin
        r = rfi_pkg::RFI_REG_ENABLE;
      end
      `RFI_OFF_STATUS_CLEAR: begin
        r = rfi_pkg::RFI_REG_CLEAR;
      end
      `RFI_OFF_STATUS_FORCE: begin
        r = rfi_pkg::RFI_REG_FORCE;
      end
      `RFI_OFF_BLK_EVENT: begin
        r = rfi_pkg::RFI_REG_BLK_EVENT;
      end
      `RFI_OFF_BLK_MASK: begin
        r = rfi_pkg::RFI_REG_BLK_MASK;
      end
      default: begin
        r = rfi_pkg::RFI_REG_NONE;
      end
    endcase
    return r;
  endfunction

  // request bundle, address widened to the decoder's width
  always_comb begin
    req.sel = PSEL;
    req.enable = PENABLE;
    req.write = PWRITE;
    req.addr = 16'h0000;
    req.addr[ADDR_W-1:0] = PADDR;
    req.wdata = PWDATA;
  end

  assign sel = decode(req.addr);

  ////////////////////////////////////////////////////////////////////////////
  // bus protocol

  rfi_apb_if u_apb (
    .clk(SYS_CLK),
    .rst(RESET),
    .req(req),
    .sel(sel),
    .rdata_next(rdata_next),
    .prdata(PRDATA),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .acc(acc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read data, taken in the setup cycle

  // clear and force are action registers and read back as zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (sel)
      rfi_pkg::RFI_REG_PENDING: begin
        rdata_next = pend & `RFI_SRC_MASK;
      end
      rfi_pkg::RFI_REG_ENABLE: begin
        rdata_next = st_q.enable & `RFI_SRC_MASK;
      end
      rfi_pkg::RFI_REG_BLK_EVENT: begin
        rdata_next[`RFI_BLK_W-1:0] = st_q.blk_event;
      end
      rfi_pkg::RFI_REG_BLK_MASK: begin
        rdata_next[`RFI_BLK_W-1:0] = st_q.blk_mask;
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // clear and force strobes

  // a write of 0 leaves a flag alone; reserved bits are dropped
  always_comb begin
    clr_bits = 32'h0000_0000;
    force_bits = 32'h0000_0000;
    if (acc.wr && acc.sel == rfi_pkg::RFI_REG_CLEAR) begin
      clr_bits = acc.wdata & `RFI_SRC_MASK;
    end
    if (acc.wr && acc.sel == rfi_pkg::RFI_REG_FORCE) begin
      force_bits = acc.wdata & `RFI_SRC_MASK;
    end
  end

  rfi_pending #(
    .W(32),
    .SRC_MASK(`RFI_SRC_MASK)
  ) u_pending (
    .clk(SYS_CLK),
    .rst(RESET),
    .evt(EVENT_IN),
    .clr(clr_bits),
    .force_set(force_bits),
    .flags(pend),
    .merged(merged)
  );

  ////////////////////////////////////////////////////////////////////////////
  // block events

  // new events of the block itself, one cycle each
  always_comb begin
    blk_new = '0;
    blk_new[`RFI_BLK_UNMAPPED] = PSLVERR;
    blk_new[`RFI_BLK_MERGED] = merged;
  end

  assign setup_rd_blk = PSEL & ~PENABLE & ~PWRITE &
    (sel == rfi_pkg::RFI_REG_BLK_EVENT);

  ////////////////////////////////////////////////////////////////////////////
  // register updates

  always_comb begin
    st_d = st_q;
    // snapshot of what the read returns; only these bits are cleared
    if (setup_rd_blk) begin
      st_d.blk_snap = st_q.blk_event;
    end
    // nvm defaults load the internal-use enables
    if (NVM_LOAD) begin
      st_d.enable[`RFI_INT_LSB +: 2] = NVM_INTERNAL;
    end
    // a driver write comes after the load so it has the last word
    if (acc.wr && acc.sel == rfi_pkg::RFI_REG_ENABLE) begin
      st_d.enable = acc.wdata & `RFI_SRC_MASK;
    end
    if (acc.wr && acc.sel == rfi_pkg::RFI_REG_BLK_MASK) begin
      st_d.blk_mask = acc.wdata[`RFI_BLK_W-1:0];
    end
    // read clears, but an event in the same cycle still sets
    if (acc.rd && acc.sel == rfi_pkg::RFI_REG_BLK_EVENT) begin
      st_d.blk_event = st_q.blk_event & ~st_q.blk_snap;
    end
    st_d.blk_event = st_d.blk_event | blk_new;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      st_q.enable <= `RFI_ENABLE_RST;
      st_q.blk_event <= `RFI_BLK_RST;
      st_q.blk_mask <= `RFI_BLK_RST;
      st_q.blk_snap <= `RFI_BLK_RST;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt outputs

  // source request: any flag whose enable is set
  assign IRQ_OUT = |(pend & st_q.enable & `RFI_SRC_MASK);
  // health of the block itself, kept apart from the source request
  assign BLK_IRQ = |(st_q.blk_event & st_q.blk_mask);
  assign PENDING_OUT = pend;

endmodule
`default_nettype wire

// ---- tb/rfi_props.sv ----
// port-level assertions of the rf irq block
`default_nettype none
module rfi_props #(
  parameter int ADDR_W = 16
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic [31:0] EVENT_IN,
  input wire logic NVM_LOAD,
  input wire logic [31:0] PENDING_OUT,
  input wire logic IRQ_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] SM = 32'h3f7f_ff3f;
  logic acc;
  logic rdx;
  logic [31:0] clr_d;
  logic [31:0] frc_d;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // write data of clear and force accesses, zero otherwise
  assign acc = PSEL && PENABLE;
  assign rdx = acc && !PWRITE;
  assign clr_d = (acc && PWRITE && PADDR == 16'h3fe8) ? PWDATA : 32'h0;
  assign frc_d = (acc && PWRITE && PADDR == 16'h3fec) ? PWDATA : 32'h0;
  ////////////////////
  a_evt_sets: assert property (
    (|(EVENT_IN & SM)) |=>
    ((PENDING_OUT & $past(EVENT_IN & SM)) == $past(EVENT_IN & SM)))
    else $error("event did not set flag");
  a_flag_sticky: assert property (
    (~PENDING_OUT & $past(PENDING_OUT) & ~$past(clr_d)) == 32'h0)
    else $error("flag fell without a clear bit");
  a_clear_drops: assert property (
    (|clr_d) |=>
    ((PENDING_OUT & $past(clr_d) & ~$past(EVENT_IN)) == 32'h0))
    else $error("clear left flag set");
  a_force_sets: assert property (
    (|(frc_d & SM)) |=>
    ((PENDING_OUT & $past(frc_d) & SM) == ($past(frc_d) & SM)))
    else $error("force did not set flag");
  a_pend_reserved: assert property (
    (PENDING_OUT & ~SM) == 32'h0)
    else $error("reserved flag set");
  a_irq_needs_flag: assert property (
    !(|PENDING_OUT) |-> !IRQ_OUT)
    else $error("irq with no flag");
  a_irq_rise_cause: assert property (
    $rose(IRQ_OUT) |-> $past(|EVENT_IN || NVM_LOAD || (acc && PWRITE)))
    else $error("irq rose with no cause");
  a_enable_read: assert property (
    (rdx && PADDR == 16'h3fe4) |-> ((PRDATA & ~SM) == 32'h0))
    else $error("reserved enable bit read 1");
  a_clear_reads0: assert property (
    (rdx && PADDR == 16'h3fe8) |-> PRDATA == 32'h0)
    else $error("clear register read nonzero");
endmodule
`default_nettype wire

// ---- tb/rfi_cpu_model.sv ----
// cpu interrupt controller stand-in: counts requests taken
`default_nettype none
module rfi_cpu_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic irq,
  output logic [15:0] hits
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_q;
  // a level request is taken once per rising edge of the line
  always_ff @(posedge clk) begin
    last_q <= rst ? 1'b0 : irq;
    if (rst) hits <= 16'h0;
    else if (irq && !last_q) hits <= hits + 16'h1;
  end
endmodule
`default_nettype wire

// ---- tb/rf_frontend_irq_enable_clear_tb_top.sv ----
// self-checking bench of the rf irq block
`default_nettype none
module rf_frontend_irq_enable_clear_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] SM = 32'h3f7f_ff3f;
  logic clk, rst, psel, pen, pwr, nld, pready, perr, irq, birq, er;
  logic [15:0] paddr, hits;
  logic [31:0] pwdata, prdata, ev, pend, rd, en, ex, s;
  logic [1:0] nvi;
  int n_errors, comparisons;
  rfi_top i_dut(.SYS_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(perr), .EVENT_IN(ev), .NVM_LOAD(nld),
    .NVM_INTERNAL(nvi), .PENDING_OUT(pend), .IRQ_OUT(irq), .BLK_IRQ(birq));
  rfi_cpu_model i_cpu(.clk(clk), .rst(rst), .irq(irq), .hits(hits));
  ////////////////////
  // compare and count; an unknown bit matches only an unknown bit in exp
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 20) begin
      n_errors++;
      summarize();
    end
  endtask
  // let the edge land, then compare flags and the request line
  task automatic flags;
    @(negedge clk);
    chk(pend, ex);
    chk({31'h0, irq}, {31'h0, |(ex & en)});
  endtask
  ////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // a hang is cut short here and counted
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    {psel, pen, pwr, nld, paddr, pwdata, ev, nvi} = '0;
    {n_errors, comparisons} = '0;
    s = 32'h3f;
    en = '0;
    ex = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 16'h3fe4, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 16'h3fe4, 32'hffff_ffff);
    apb(1'b0, 16'h3fe4, 32'h0);
    chk(rd, SM);
    apb(1'b0, 16'h3fe8, 32'h0);
    chk(rd, 32'h0);
    $display("register test done");
    // random enable, force, event and clear rounds
    repeat (12) begin
      s = nxt(s);
      en = s & SM;
      apb(1'b1, 16'h3fe4, s);
      apb(1'b0, 16'h3fe4, 32'h0);
      chk(rd, en);
      s = nxt(s);
      ex |= s & SM;
      apb(1'b1, 16'h3fec, s);
      flags();
      s = nxt(s);
      @(posedge clk);
      ev <= s;
      @(posedge clk);
      ev <= 32'h0;
      ex |= s & SM;
      flags();
      apb(1'b1, 16'h3fe8, 32'h0);
      flags();
      apb(1'b0, 16'h3fe0, 32'h0);
      chk(rd, ex);
      s = nxt(s);
      ex &= ~s;
      apb(1'b1, 16'h3fe8, s);
      flags();
    end
    $display("random test done");
    // default load of the internal bits, then a forced internal flag
    @(posedge clk);
    nvi <= 2'b10;
    nld <= 1'b1;
    @(posedge clk);
    nld <= 1'b0;
    en = (en & ~32'h6000) | 32'h4000;
    apb(1'b0, 16'h3fe4, 32'h0);
    chk(rd, en);
    ex |= 32'h4000;
    apb(1'b1, 16'h3fec, 32'h4000);
    flags();
    // pending status ignores writes; an event in the clearing cycle wins
    apb(1'b1, 16'h3fe0, 32'hffff_ffff);
    flags();
    fork
      apb(1'b1, 16'h3fe8, 32'h0001_0000);
      begin
        repeat (2) @(posedge clk);
        ev <= 32'h0001_0000;
        @(posedge clk);
        ev <= 32'h0;
      end
    join
    ex |= 32'h0001_0000;
    flags();
    // a repeat event on a set flag is logged as merged
    @(posedge clk);
    ev <= 32'h0001_0000;
    @(posedge clk);
    ev <= 32'h0;
    flags();
    $display("corner test done");
    // unmapped access raises the block interrupt; mask, then read-clear
    apb(1'b1, 16'h3ff4, 32'h1);
    apb(1'b0, 16'h3ff4, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 16'h3fec, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 16'h1000, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    @(negedge clk);
    chk({31'h0, birq}, 32'h1);
    apb(1'b1, 16'h3ff4, 32'h0);
    @(negedge clk);
    chk({31'h0, birq}, 32'h0);
    apb(1'b1, 16'h3ff4, 32'h1);
    apb(1'b0, 16'h3ff0, 32'h0);
    chk({30'h0, rd[1:0]}, 32'h3);
    @(negedge clk);
    chk({31'h0, birq}, 32'h0);
    chk({31'h0, hits != 16'h0}, 32'h1);
    $display("block test done");
    // a second reset in mid-run clears flags and enables
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    ex = '0;
    en = '0;
    flags();
    apb(1'b0, 16'h3fe4, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
    summarize();
  end
endmodule
bind rfi_top rfi_props #(.ADDR_W(ADDR_W)) i_props(.SYS_CLK(SYS_CLK),
  .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .EVENT_IN(EVENT_IN),
  .NVM_LOAD(NVM_LOAD), .PENDING_OUT(PENDING_OUT), .IRQ_OUT(IRQ_OUT));
`default_nettype wire
